/* inc/bgw_pkg.sv */
// Package for the dual boot-guard watchdog: timing constants and state types.
// Assumes a single 20 MHz core clock; all other rates come from a tick enable.
`default_nettype none
package bgw_pkg;

    // ------------------------------------------------------------------
    // Clock and tick
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 20000000;
    localparam int unsigned TICK_HZ       = 1000;          // Millisecond tick
    localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
    localparam int unsigned DIV_W         = 15;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

    // ------------------------------------------------------------------
    // Timeouts in their own units and as tick counts
    // ------------------------------------------------------------------
    localparam int unsigned SEL_TIMEOUT_S   = 10;
    localparam int unsigned POWER_ON_SELFTEST_TIMEOUT_MIN = 12;
    localparam int unsigned SEL_TICKS  = SEL_TIMEOUT_S * TICK_HZ;
    localparam int unsigned POWER_ON_SELFTEST_TICKS = POWER_ON_SELFTEST_TIMEOUT_MIN * 60 * TICK_HZ;
    localparam int unsigned CNT_W      = 20;

    // ------------------------------------------------------------------
    // Reset pulse and timer state
    // ------------------------------------------------------------------
    localparam int unsigned RST_PULSE_CYC = 16;
    localparam int unsigned PULSE_W       = 5;

    typedef enum logic [1:0] {
        BGW_IDLE,
        BGW_RUN,
        BGW_FIRED
    } bgw_state_t;

endpackage
`default_nettype wire

/* verilog/bgw_timer.sv */
// One watchdog timer: counts ticks while armed and fires once at its limit.
// Assumes arm, disarm and tick are synchronous one-cycle pulses on core_clk.
`timescale 1ns/1ps
`default_nettype none

module bgw_timer (
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    input  wire logic                        tick,
    input  wire logic                        arm,
    input  wire logic                        disarm,
    input  wire logic                        clear,
    input  wire logic [bgw_pkg::CNT_W-1:0]   limit,
    output logic                             running,
    output logic                             expire
);

    bgw_pkg::bgw_state_t                     state_ff;
    logic [bgw_pkg::CNT_W-1:0]               count_ff;

    // ------------------------------------------------------------------
    // State: arm starts a fresh count, disarm holds it, expiry fires once
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst || clear) begin
            state_ff <= bgw_pkg::BGW_IDLE;
        end else begin
            case (state_ff)
                bgw_pkg::BGW_IDLE:  if (arm) state_ff <= bgw_pkg::BGW_RUN;
                bgw_pkg::BGW_RUN: begin
                    if (disarm)
                        state_ff <= bgw_pkg::BGW_IDLE;
                    else if (tick && count_ff == limit - 1'b1)
                        state_ff <= bgw_pkg::BGW_FIRED;
                end
                bgw_pkg::BGW_FIRED: state_ff <= bgw_pkg::BGW_FIRED;
                default:            state_ff <= bgw_pkg::BGW_IDLE;
            endcase
        end
    end

    // Tick counter, held while disarmed
    always_ff @(posedge core_clk) begin
        if (!nrst || clear) begin
            count_ff <= '0;
        end else if (state_ff == bgw_pkg::BGW_IDLE && arm) begin
            count_ff <= '0;
        end else if (state_ff == bgw_pkg::BGW_RUN && tick && !disarm) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    // Single-cycle expiry pulse
    always_ff @(posedge core_clk) begin
        if (!nrst || clear)
            expire <= 1'b0;
        else
            expire <= state_ff == bgw_pkg::BGW_RUN && !disarm && tick
                      && count_ff == limit - 1'b1;
    end

    assign running = state_ff == bgw_pkg::BGW_RUN;

endmodule // bgw_timer
`default_nettype wire

/* verilog/bgw_dual_watchdog.sv */
// Top of the dual boot-guard watchdog inside the board management controller.
// Assumes the firmware strobes are synchronous one-cycle pulses on core_clk and
// that hard_reset is a synchronous level, high while the system is held in reset.
`timescale 1ns/1ps
`default_nettype none

module bgw_dual_watchdog #(
    parameter int unsigned SEL_TICKS  = bgw_pkg::SEL_TICKS,
    parameter int unsigned POWER_ON_SELFTEST_TICKS = bgw_pkg::POWER_ON_SELFTEST_TICKS
) (
    input  wire logic  core_clk,
    input  wire logic  nrst,
    input  wire logic  hard_reset,
    input  wire logic  sel_disarm,
    input  wire logic  power_on_selftest_arm,
    input  wire logic  power_on_selftest_disarm,
    input  wire logic  proc_disable_clr,
    output logic       system_reset,
    output logic       async_system_reset,
    output logic       boot_processor_disable,
    output logic       sel_running,
    output logic       power_on_selftest_running,
    output logic       sel_expired,
    output logic       power_on_selftest_expired
);

    // ------------------------------------------------------------------
    // Millisecond tick divider
    // ------------------------------------------------------------------
    logic [bgw_pkg::DIV_W-1:0]   div_ff;
    logic                        tick;

    // Divider counts core clocks to one tick
    always_ff @(posedge core_clk) begin
        if (!nrst)
            div_ff <= '0;
        else if (div_ff == bgw_pkg::DIV_LAST)
            div_ff <= '0;
        else
            div_ff <= div_ff + 1'b1;
    end

    assign tick = div_ff == bgw_pkg::DIV_LAST;

    // ------------------------------------------------------------------
    // Hard reset release detect
    // ------------------------------------------------------------------
    logic                        hard_reset_ff;
    logic                        hr_release;

    always_ff @(posedge core_clk) begin
        if (!nrst)
            hard_reset_ff <= 1'b1;
        else
            hard_reset_ff <= hard_reset;
    end

    assign hr_release = hard_reset_ff && !hard_reset;

    // ------------------------------------------------------------------
    // The two timers
    // ------------------------------------------------------------------
    logic                        sel_expire;
    logic                        power_on_selftest_expire;

    // Boot-select timer, armed by release of hard reset
    bgw_timer u_sel (
        .core_clk (core_clk),
        .nrst     (nrst),
        .tick     (tick),
        .arm      (hr_release),
        .disarm   (sel_disarm),
        .clear    (hard_reset),
        .limit    (bgw_pkg::CNT_W'(SEL_TICKS)),
        .running  (sel_running),
        .expire   (sel_expire)
    );

    // Self-test progress timer, armed by firmware
    bgw_timer u_power_on_selftest (
        .core_clk (core_clk),
        .nrst     (nrst),
        .tick     (tick),
        .arm      (power_on_selftest_arm),
        .disarm   (power_on_selftest_disarm),
        .clear    (hard_reset),
        .limit    (bgw_pkg::CNT_W'(POWER_ON_SELFTEST_TICKS)),
        .running  (power_on_selftest_running),
        .expire   (power_on_selftest_expire)
    );

    // ------------------------------------------------------------------
    // Expiry actions
    // ------------------------------------------------------------------
    logic [bgw_pkg::PULSE_W-1:0] sys_cnt_ff;
    logic [bgw_pkg::PULSE_W-1:0] areset_cnt_ff;

    // System reset pulse after boot-select expiry
    always_ff @(posedge core_clk) begin
        if (!nrst)
            sys_cnt_ff <= '0;
        else if (sel_expire)
            sys_cnt_ff <= bgw_pkg::PULSE_W'(bgw_pkg::RST_PULSE_CYC);
        else if (sys_cnt_ff != '0)
            sys_cnt_ff <= sys_cnt_ff - 1'b1;
    end

    // Async system reset pulse after self-test expiry
    always_ff @(posedge core_clk) begin
        if (!nrst)
            areset_cnt_ff <= '0;
        else if (power_on_selftest_expire)
            areset_cnt_ff <= bgw_pkg::PULSE_W'(bgw_pkg::RST_PULSE_CYC);
        else if (areset_cnt_ff != '0)
            areset_cnt_ff <= areset_cnt_ff - 1'b1;
    end

    // Registered reset outputs
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            system_reset       <= 1'b0;
            async_system_reset <= 1'b0;
        end else begin
            system_reset       <= sel_expire || sys_cnt_ff > 1;
            async_system_reset <= power_on_selftest_expire || areset_cnt_ff > 1;
        end
    end

    // Processor disable: set only by boot-select expiry, set beats clear
    always_ff @(posedge core_clk) begin
        if (!nrst)
            boot_processor_disable <= 1'b0;
        else if (sel_expire)
            boot_processor_disable <= 1'b1;
        else if (proc_disable_clr)
            boot_processor_disable <= 1'b0;
    end

    // Sticky expiry status, cleared by the next hard reset; set wins
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sel_expired  <= 1'b0;
            power_on_selftest_expired <= 1'b0;
        end else begin
            sel_expired  <= sel_expire || (sel_expired && !hard_reset);
            power_on_selftest_expired <= power_on_selftest_expire || (power_on_selftest_expired && !hard_reset);
        end
    end

endmodule // bgw_dual_watchdog
`default_nettype wire

/* verif/bgw_dual_props.sv */
// Checker for the dual boot-guard watchdog ports.
// Assumes core_clk domain only and the synchronous active-low nrst.
`timescale 1ns/1ps
`default_nettype none
module bgw_dual_props (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic hard_reset,
    input wire logic sel_disarm,
    input wire logic power_on_selftest_arm,
    input wire logic power_on_selftest_disarm,
    input wire logic proc_disable_clr,
    input wire logic system_reset,
    input wire logic async_system_reset,
    input wire logic boot_processor_disable,
    input wire logic sel_running,
    input wire logic power_on_selftest_running,
    input wire logic sel_expired,
    input wire logic power_on_selftest_expired
);
    // ------------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Reset outputs stand 16 cycles, then drop
    AST_SYS_PULSE: assert property ($rose(system_reset) |-> system_reset[*8] ##1 system_reset[*8] ##1 !system_reset) else $error("system reset pulse length");
    AST_ASR_PULSE: assert property ($rose(async_system_reset) |-> async_system_reset[*8] ##1 async_system_reset[*8] ##1 !async_system_reset) else $error("async reset pulse length");
    AST_SEL_DIS: assert property ($rose(system_reset) |-> boot_processor_disable && sel_expired) else $error("processor not disabled");
    AST_ASR_KEEP: assert property ($rose(async_system_reset) |-> power_on_selftest_expired && $stable(boot_processor_disable)) else $error("processor state changed");
    AST_SEL_ARM: assert property ($fell(hard_reset) |=> sel_running) else $error("boot select not armed");
    AST_HR_CLR: assert property (hard_reset |=> !sel_running && !power_on_selftest_running && !sel_expired && !power_on_selftest_expired) else $error("timers not cleared");
    AST_POWER_ON_SELFTEST_ARM: assert property (power_on_selftest_arm && !power_on_selftest_running && !power_on_selftest_expired && !hard_reset |=> power_on_selftest_running) else $error("self-test not armed");
    AST_SEL_OFF: assert property (sel_disarm && sel_running && !hard_reset |=> !sel_running) else $error("disarm ignored");
    AST_EXP_SRC: assert property ($rose(sel_expired) |-> $past(sel_running, 2)) else $error("expiry while disarmed");
    AST_CLR: assert property (proc_disable_clr && !$rose(system_reset) |=> !boot_processor_disable || $rose(system_reset)) else $error("disable not cleared");
    COV_SEL: cover property ($rose(system_reset));
    COV_ASR: cover property ($rose(async_system_reset));
    COV_OFF: cover property (power_on_selftest_disarm && power_on_selftest_running);
endmodule // bgw_dual_props
`default_nettype wire

/* verif/bgw_fw_model.sv */
// Boot processor firmware model: arms the self-test timer and disarms the two timers.
// Assumes start and finish are one-cycle pulses from the bench.
`timescale 1ns/1ps
`default_nettype none
module bgw_fw_model (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic start,
    input  wire logic finish,
    output logic      sel_disarm,
    output logic      power_on_selftest_arm,
    output logic      power_on_selftest_disarm
);
    // ------------------------------------------------------------------
    // Strobe sequence
    // ------------------------------------------------------------------
    logic [1:0] seq_ff;
    // Self-test timer first, boot-select disarm two cycles later
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            seq_ff      <= 2'h0;
            power_on_selftest_arm    <= 1'b0;
            sel_disarm  <= 1'b0;
            power_on_selftest_disarm <= 1'b0;
        end else begin
            power_on_selftest_arm    <= start;
            seq_ff      <= {seq_ff[0], start};
            sel_disarm  <= seq_ff[1];
            power_on_selftest_disarm <= finish;
        end
    end
endmodule // bgw_fw_model
`default_nettype wire

/* verif/tb.sv */
// Testbench for the dual boot-guard watchdog with a firmware model.
// Assumes short tick limits so each expiry takes at most two ticks.
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ------------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------------
    localparam int TK = bgw_pkg::TICK_DIV;
    logic core_clk, nrst, hard_reset, proc_disable_clr, start, finish;
    logic sel_disarm, power_on_selftest_arm, power_on_selftest_disarm, system_reset, async_system_reset;
    logic boot_processor_disable, sel_running, power_on_selftest_running, sel_expired, power_on_selftest_expired;
    int   fails = 0, check_count = 0, n;
    bit   dead = 1'b0;
    // Boot-select counts two ticks, self-test one, to keep the run short
    bgw_dual_watchdog #(.SEL_TICKS(2), .POWER_ON_SELFTEST_TICKS(1)) u_dut (
        .core_clk(core_clk), .nrst(nrst), .hard_reset(hard_reset),
        .sel_disarm(sel_disarm), .power_on_selftest_arm(power_on_selftest_arm), .power_on_selftest_disarm(power_on_selftest_disarm),
        .proc_disable_clr(proc_disable_clr), .system_reset(system_reset),
        .async_system_reset(async_system_reset),
        .boot_processor_disable(boot_processor_disable),
        .sel_running(sel_running), .power_on_selftest_running(power_on_selftest_running),
        .sel_expired(sel_expired), .power_on_selftest_expired(power_on_selftest_expired)
    );
    bgw_fw_model u_fw (
        .core_clk(core_clk), .nrst(nrst), .start(start), .finish(finish),
        .sel_disarm(sel_disarm), .power_on_selftest_arm(power_on_selftest_arm), .power_on_selftest_disarm(power_on_selftest_disarm)
    );
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Advance to a rising edge; drives that follow land on it by NBA
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    // Look at outputs only once the last edge has settled
    task automatic look();
        @(negedge core_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // One-cycle hard reset and start strobes, then settle
    task automatic pulse(input bit hr, input bit st);
        cyc(1);
        hard_reset <= hr;
        start      <= st;
        cyc(1);
        hard_reset <= 1'b0;
        start      <= 1'b0;
        cyc(4);
        look();
    endtask
    // Wait for a reset output, counting cycles from now; a spent bound fails
    task automatic wait_rst(input bit on_async);
        n = 0;
        while ((on_async ? async_system_reset : system_reset) !== 1'b1 && n < 3 * TK) begin
            look();
            n++;
        end
        if (n >= 3 * TK) begin
            fails++;
            dead = 1'b1;
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_guarded();
        pulse(1'b1, 1'b1);
        chk({sel_running, power_on_selftest_running}, 32'h1);
        wait_rst(1'b1);
        if (dead) return;
        chk(n <= TK + 4, 32'h1);
        chk({boot_processor_disable, system_reset, power_on_selftest_expired}, 32'h1);
        pulse(1'b1, 1'b0);
        chk({sel_expired, power_on_selftest_expired, power_on_selftest_running, sel_running}, 32'h1);
        $display("t_guarded done");
    endtask
    // Disarmed self-test timer must stay silent past its whole timeout
    task automatic t_power_on_selftest_off();
        pulse(1'b1, 1'b1);
        chk({sel_running, power_on_selftest_running}, 32'h1);
        cyc(1);
        finish <= 1'b1;
        cyc(1);
        finish <= 1'b0;
        repeat (TK + 8) look();
        chk({sel_running, power_on_selftest_running, power_on_selftest_expired, async_system_reset}, 32'h0);
        chk({sel_expired, system_reset, boot_processor_disable}, 32'h0);
        $display("t_power_on_selftest_off done");
    endtask
    task automatic t_sel_fire();
        pulse(1'b1, 1'b0);
        wait_rst(1'b0);
        if (dead) return;
        chk(n > TK - 8 && n <= 2 * TK + 4, 32'h1);
        chk({boot_processor_disable, sel_expired, async_system_reset}, 32'h6);
        cyc(1);
        proc_disable_clr <= 1'b1;
        cyc(1);
        proc_disable_clr <= 1'b0;
        cyc(20);
        look();
        chk({boot_processor_disable, system_reset, sel_running}, 32'h0);
        $display("t_sel_fire done");
    endtask
    initial begin
        nrst             <= 1'b0;
        hard_reset       <= 1'b1;
        proc_disable_clr <= 1'b0;
        start            <= 1'b0;
        finish           <= 1'b0;
        cyc(2);
        nrst <= 1'b1;
        t_guarded();
        if (!dead) t_power_on_selftest_off();
        if (!dead) t_sel_fire();
        summarize();
    end
endmodule // tb
bind bgw_dual_watchdog bgw_dual_props u_props (.*);
`default_nettype wire
